// [hw/ldr_pkg.sv]
package ldr_pkg;

   // Register identity and layout
   localparam logic [7:0] REQ_LOW_OFFSET = 8'h38;   // Register address
   localparam int REG_WIDTH = 16;                   // Defined field bits
   localparam int RSP_WIDTH = 20;                   // Read response width
   localparam logic [15:0] REQ_RESET = 16'h0000;    // Value after any reset
   localparam int NUM_CH = 8;                       // Loop channels

   // Field positions
   localparam int MODE_BIT = 15;
   localparam int LEVEL_BIT = 14;
   localparam int PD_BIT = 13;
   localparam int SRC_MSB = 12;
   localparam int SRC_LSB = 11;
   localparam int SINK_BIT = 10;
   localparam int MON_MSB = 9;
   localparam int MON_LSB = 8;
   localparam int RES_MSB = 7;
   localparam int RES_LSB = 4;
   localparam int LEAK_MSB = 3;
   localparam int LEAK_LSB = 0;
   localparam int HL_TYPE_MSB = 7;
   localparam int HL_TYPE_LSB = 5;
   localparam int HL_PIN_BIT = 4;

   // Field encodings
   localparam logic [1:0] SRC_OFF = 2'h0;
   localparam logic [1:0] SRC_ON = 2'h1;
   localparam logic [1:0] SRC_BYPASS = 2'h2;
   localparam logic [1:0] SRC_ON_AMP = 2'h3;
   localparam logic [1:0] MON_OFF = 2'h0;
   localparam logic [1:0] MON_HIGH = 2'h1;
   localparam logic [1:0] MON_LOW_PD_OFF = 2'h2;
   localparam logic [1:0] MON_LOW_PD_ON = 2'h3;
   localparam logic [3:0] CH_LAST = 4'h7;

   // Analog control outputs, per channel
   typedef struct packed {
      logic [7:0] source_on;        // High-side source current on
      logic [7:0] bypass_on;        // Bypass current on
      logic source_level_8ma;       // 1: 8 mA, 0: 40 mA
      logic [7:0] sink_on;          // Low-side sink on
      logic [7:0] mon_high_side;    // Monitor to high-side pin
      logic [7:0] mon_low_side;     // Monitor to low-side pin
      logic [7:0] pulldown_on;      // Pull-down current on
      logic [7:0] diff_amp_sel;     // Resistance amplifier channel
      logic [7:0] res_mux_sel;      // Resistance path and full-path test channel
      logic [7:0] leak_mux_sel;     // Leakage path and HS/LS test channel
   } ldr_ctrl_type;

   // High-level request view
   typedef struct packed {
      logic valid;                  // Mode bit set
      logic [2:0] diag_type;        // High-level diagnostic type
      logic pin_sel;                // 1: high-side pin, 0: low-side pin
      logic [3:0] channel;          // Channel selector
   } ldr_hl_req_type;

endpackage

// [hw/ldr_loop_diag_low_level_config.sv]
`timescale 1ns/1ps
module ldr_loop_diag_low_level_config (
   input wire logic i_sys_clk,                     // 200 MHz clock
   input wire logic i_reset_n,                     // Power-on reset, sync, active low
   input wire logic i_warm_reset_state,            // Warm reset state request
   input wire logic i_soft_reset,                  // Soft reset request
   input wire logic i_wr_en,                       // Register write strobe
   input wire logic i_rd_en,                       // Register read strobe
   input wire logic [7:0] i_addr,                  // Register address
   input wire logic [15:0] i_wr_data,              // Write data
   output logic [19:0] o_rd_data,                  // Read response data
   output logic o_rd_valid,                        // Read response valid
   output logic [15:0] o_request,                  // Raw register contents
   output ldr_pkg::ldr_hl_req_type o_hl_request,   // High-level request view
   output ldr_pkg::ldr_ctrl_type o_ctrl            // Analog control lines
);

   // Block notes
   // - Only address 8'h38 is decoded; other addresses are ignored.
   // - A warm or soft reset clears the register and beats a write.
   // - A read in the same cycle as a write returns the old value.
   // - The decoded controls lag the stored register by one cycle.
   // - In high-level mode every low-level line is off and all
   //   pull-downs stay on; the sequencer outside takes over.
   // - Monitor code 11 with source or sink on is not blocked:
   //   keeping them off is left to the host.
   // - Selector codes above 7 open every mux on purpose.
   // - Read answers carry zeros in the four top bits.
   // - Controls hold between writes; rewriting a value is glitch free.
   // - Warm and soft reset are levels; holding them holds the clear.
   // - The power-on reset also clears the read answer.
   // - The pair partner of channel n is n with its low bit flipped.
   // - The sink current limit lives in the analog part, not here.
   // - The source level bit applies to source codes 01 and 11.
   // - Bypass (source code 10) has no level choice.
   // - Pull-down policy set overrides every monitor code.
   // - The high-level view repeats raw fields without checking them.
   // - Nothing here times or sequences a measurement.

   // Channel decode: one-hot for codes 0..7, nothing above
   // Codes 8..15 leave every mux open, so a stray write
   // can never steer current into a wrong loop
   function automatic logic [7:0] ch_decode(input logic [3:0] sel);
      logic [7:0] oh;
      // Default: no channel selected
      oh = 8'h00;
      if (sel <= ldr_pkg::CH_LAST)
      begin
         oh[sel[2:0]] = 1'b1;
      end
      return oh;
   endfunction

   // Partner of a channel pair: swap the low bit
   // Channels pair as 0/1, 2/3, 4/5 and 6/7
   // Used by the amplifier routing of source code 11
   function automatic logic [7:0] pair_swap(input logic [7:0] oh);
      logic [7:0] sw;
      sw = 8'h00;
      // Move every channel onto its partner
      for (int i = 0; i < ldr_pkg::NUM_CH; i++)
      begin
         sw[i ^ 1] = oh[i];
      end
      return sw;
   endfunction

   // Register state
   logic [15:0] req_r;                 // Stored register
   logic [15:0] req_nxt;               // Next register value

   // Read response state
   logic [19:0] rd_data_r;             // Read response
   logic [19:0] rd_data_nxt;           // Next read response
   logic rd_valid_r;                   // Read answer strobe
   logic rd_valid_nxt;                 // Next read answer strobe

   // Decoded outputs, registered so every output leaves a flip-flop
   ldr_pkg::ldr_ctrl_type ctrl_r;      // Registered analog controls
   ldr_pkg::ldr_ctrl_type ctrl_nxt;    // Next analog controls
   ldr_pkg::ldr_hl_req_type hl_r;      // Registered high-level view
   ldr_pkg::ldr_hl_req_type hl_nxt;    // Next high-level view

   // Bus decode
   logic addr_hit;                     // Address matches this register
   logic wr_hit;                       // Write taken this cycle
   logic rd_hit;                       // Read taken this cycle
   logic any_reset;                    // Warm or soft reset requested

   assign addr_hit = (i_addr == ldr_pkg::REQ_LOW_OFFSET);
   assign wr_hit = i_wr_en && addr_hit;                   // Write to this register
   assign rd_hit = i_rd_en && addr_hit;                   // Read of this register
   assign any_reset = i_warm_reset_state || i_soft_reset; // Either clearing reset

   // Register next value: resets clear, write loads
   // A reset in the same cycle as a write wins, so the host
   // never sees a half-applied write after a soft reset
   always_comb
   begin
      // Hold by default
      req_nxt = req_r;
      if (any_reset)
      begin
         // Warm or soft reset clears every field
         req_nxt = ldr_pkg::REQ_RESET;
      end
      else if (wr_hit)
      begin
         // Host write loads all sixteen bits at once
         req_nxt = i_wr_data;
      end
   end

   // Read response next value
   // Data holds between reads; the strobe lasts one cycle
   always_comb
   begin
      // Strobe answers only a read of this address
      rd_valid_nxt = rd_hit;
      rd_data_nxt = rd_data_r;
      if (rd_hit)
      begin
         // Unused upper response bits read as zero
         rd_data_nxt = {4'h0, req_r};
      end
   end

   // Decode fields into analog controls
   // Everything defaults to off, so an unused code
   // leaves the loops in their safest state
   // Controls follow the register one cycle later
   always_comb
   begin
      logic [7:0] res_oh;
      logic [7:0] leak_oh;
      logic [1:0] src;
      logic [1:0] mon;
      logic [7:0] attached;
      logic [7:0] pd_keep;
      // One-hot channel masks from both selectors
      res_oh = ch_decode(req_r[ldr_pkg::RES_MSB:ldr_pkg::RES_LSB]);
      leak_oh = ch_decode(req_r[ldr_pkg::LEAK_MSB:ldr_pkg::LEAK_LSB]);
      // Field slices used by the case statements
      src = req_r[ldr_pkg::SRC_MSB:ldr_pkg::SRC_LSB];
      mon = req_r[ldr_pkg::MON_MSB:ldr_pkg::MON_LSB];
      // Start from all-off
      ctrl_nxt = '0;
      attached = 8'h00;
      pd_keep = 8'h00;
      hl_nxt = '0;
      if (!req_r[ldr_pkg::MODE_BIT])
      begin
         // Low-level mode: fields drive the hardware directly
         // Muxes follow both selectors in low-level mode
         ctrl_nxt.res_mux_sel = res_oh;
         ctrl_nxt.leak_mux_sel = leak_oh;
         ctrl_nxt.source_level_8ma = req_r[ldr_pkg::LEVEL_BIT];
         unique case (src)
            // Source off everywhere
            ldr_pkg::SRC_OFF:
            begin
               ctrl_nxt.source_on = 8'h00;
            end
            // Source current on the resistance channel
            ldr_pkg::SRC_ON:
            begin
               ctrl_nxt.source_on = res_oh;
            end
            // Bypass current on the resistance channel
            ldr_pkg::SRC_BYPASS:
            begin
               ctrl_nxt.bypass_on = res_oh;
            end
            // Source current plus amplifier on the partner
            ldr_pkg::SRC_ON_AMP:
            begin
               ctrl_nxt.source_on = res_oh;
               ctrl_nxt.diff_amp_sel = pair_swap(res_oh);
            end
         endcase
         // Sink follows the resistance channel only
         if (req_r[ldr_pkg::SINK_BIT])
         begin
            ctrl_nxt.sink_on = res_oh;
         end
         unique case (mon)
            // Monitor disconnected
            ldr_pkg::MON_OFF:
            begin
               ctrl_nxt.mon_high_side = 8'h00;
            end
            // Monitor on the leakage channel high-side pin
            ldr_pkg::MON_HIGH:
            begin
               ctrl_nxt.mon_high_side = leak_oh;
            end
            // Monitor on the low-side pin, pull-down dropped
            ldr_pkg::MON_LOW_PD_OFF:
            begin
               ctrl_nxt.mon_low_side = leak_oh;
            end
            // Monitor on the low-side pin, pull-down kept
            ldr_pkg::MON_LOW_PD_ON:
            begin
               // Host has already turned source and sink off
               ctrl_nxt.mon_low_side = leak_oh;
               pd_keep = leak_oh;
            end
         endcase
         // Channels tied to monitor, sink or source lose pull-down
         // Monitor code 11 keeps its pull-down, masked below
         attached = ctrl_nxt.source_on | ctrl_nxt.bypass_on | ctrl_nxt.sink_on
            | ctrl_nxt.mon_high_side | ctrl_nxt.mon_low_side;
         // Policy set: every pull-down off
         // Policy clear: only attached channels lose it
         if (req_r[ldr_pkg::PD_BIT])
         begin
            ctrl_nxt.pulldown_on = 8'h00;
         end
         else
         begin
            ctrl_nxt.pulldown_on = ~(attached & ~pd_keep);
         end
      end
      else
      begin
         // High-level mode: reinterpret fields as a request
         // The outside sequencer owns the loops; keep them pulled down
         ctrl_nxt.pulldown_on = 8'hff;
         hl_nxt.valid = 1'b1;
         // Type and pin bits share the resistance selector field
         hl_nxt.diag_type = req_r[ldr_pkg::HL_TYPE_MSB:ldr_pkg::HL_TYPE_LSB];
         hl_nxt.pin_sel = req_r[ldr_pkg::HL_PIN_BIT];
         // Channel reuses the leakage selector field
         hl_nxt.channel = req_r[ldr_pkg::LEAK_MSB:ldr_pkg::LEAK_LSB];
      end
   end

   // Register group: power-on reset clears the stored fields
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_reset_n)
      begin
         req_r <= ldr_pkg::REQ_RESET;
      end
      else
      begin
         req_r <= req_nxt;
      end
   end

   // Read response group: no answer pending after reset
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_reset_n)
      begin
         rd_data_r <= 20'h00000;
         rd_valid_r <= 1'b0;
      end
      else
      begin
         rd_data_r <= rd_data_nxt;
         rd_valid_r <= rd_valid_nxt;
      end
   end

   // Decoded outputs: all lines off while reset is held
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_reset_n)
      begin
         ctrl_r <= '0;
         hl_r <= '0;
      end
      else
      begin
         ctrl_r <= ctrl_nxt;
         hl_r <= hl_nxt;
      end
   end

   // Outputs come straight from the flip-flops above
   assign o_request = req_r;
   assign o_rd_data = rd_data_r;
   assign o_rd_valid = rd_valid_r;
   assign o_ctrl = ctrl_r;
   assign o_hl_request = hl_r;

endmodule

// [sim/ldr_asserts.sv]
`timescale 1ns/1ps
module ldr_asserts (
   input wire logic i_sys_clk, // Clock
   input wire logic i_reset_n, // Reset, active low
   input wire logic i_soft_reset, // Soft reset
   input wire logic [19:0] o_rd_data, // Read data
   input wire logic o_rd_valid, // Read valid
   input wire logic [15:0] o_request, // Register contents
   input wire ldr_pkg::ldr_hl_req_type o_hl_request, // High-level view
   input wire ldr_pkg::ldr_ctrl_type o_ctrl // Control lines
);
   logic [15:0] q_r; // Register one cycle back, aligned with o_ctrl
   logic v_r; // Reset was already released one cycle back
   // Delay the register so each check sees the value o_ctrl was built from
   always_ff @(posedge i_sys_clk)
   begin
      q_r <= o_request;
      v_r <= i_reset_n;
   end
   wire lo = v_r && !q_r[15]; // Low-level mode in force
   wire [7:0] rs = q_r[7] ? 8'h00 : 8'h01 << q_r[6:4]; // Resistance channel
   wire [7:0] lk = q_r[3] ? 8'h00 : 8'h01 << q_r[2:0]; // Leakage channel
   wire [7:0] pr = {rs[6], rs[7], rs[4], rs[5], rs[2], rs[3], rs[0], rs[1]}; // Pair partner
   wire [7:0] mt = (q_r[9:8] == 2'h1 || q_r[9:8] == 2'h2) ? lk : 8'h00; // Monitor target
   wire [7:0] at = ((q_r[12:10] != 3'h0) ? rs : 8'h00) | mt; // Attached channels
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_reset_n);
   property p_src;
      lo |-> o_ctrl.source_on == (q_r[11] ? rs : 8'h00) && o_ctrl.source_level_8ma == q_r[14];
   endproperty
   a_src: assert property (p_src) else $error("source current mismatch");
   property p_byp;
      lo |-> o_ctrl.bypass_on == ((q_r[12:11] == 2'h2) ? rs : 8'h00);
   endproperty
   a_byp: assert property (p_byp) else $error("bypass mismatch");
   property p_amp;
      lo |-> o_ctrl.diff_amp_sel == ((q_r[12:11] == 2'h3) ? pr : 8'h00);
   endproperty
   a_amp: assert property (p_amp) else $error("amplifier channel mismatch");
   property p_sink;
      lo |-> o_ctrl.sink_on == (q_r[10] ? rs : 8'h00);
   endproperty
   a_sink: assert property (p_sink) else $error("sink mismatch");
   property p_mon;
      lo |-> (o_ctrl.mon_high_side == (mt & ~{8{q_r[9]}}))
         && (o_ctrl.mon_low_side == (q_r[9] ? lk : 8'h00));
   endproperty
   a_mon: assert property (p_mon) else $error("monitor mismatch");
   property p_pd;
      lo |-> o_ctrl.pulldown_on == (q_r[13] ? 8'h00 : ~at);
   endproperty
   a_pd: assert property (p_pd) else $error("pull-down mismatch");
   property p_mux;
      lo |-> o_ctrl.res_mux_sel == rs && o_ctrl.leak_mux_sel == lk;
   endproperty
   a_mux: assert property (p_mux) else $error("mux select mismatch");
   property p_hl;
      v_r |-> o_hl_request == (q_r[15] ? {1'b1, q_r[7:0]} : 9'h000);
   endproperty
   a_hl: assert property (p_hl) else $error("high-level view mismatch");
   property p_rd;
      o_rd_valid |-> o_rd_data == {4'h0, $past(o_request)};
   endproperty
   a_rd: assert property (p_rd) else $error("read data mismatch");
   property p_soft;
      i_soft_reset |=> o_request == 16'h0000;
   endproperty
   a_soft: assert property (p_soft) else $error("soft reset did not clear");
   c_amp: cover property (lo && q_r[12:11] == 2'h3);
   c_hl: cover property (v_r && q_r[15]);
   c_rd: cover property (o_rd_valid && o_rd_data != 20'h00000);
endmodule
bind ldr_loop_diag_low_level_config ldr_asserts u_chk (.i_sys_clk(i_sys_clk),
   .i_reset_n(i_reset_n), .i_soft_reset(i_soft_reset), .o_rd_data(o_rd_data),
   .o_rd_valid(o_rd_valid), .o_request(o_request), .o_hl_request(o_hl_request),
   .o_ctrl(o_ctrl));

// [sim/ldr_host_model.sv]
`timescale 1ns/1ps
module ldr_host_model (
   input wire logic i_sys_clk, // Clock
   output logic o_wr_en = 1'b0, // Write strobe
   output logic o_rd_en = 1'b0, // Read strobe
   output logic [7:0] o_addr = 8'h00, // Address
   output logic [15:0] o_wr_data = 16'h0000 // Write data
);
   // One write, called at a falling edge; idle lines invert so no stale value rests
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      o_addr = a;
      o_wr_data = d;
      o_wr_en = 1'b1;
      @(negedge i_sys_clk);
      o_wr_en = 1'b0;
      o_addr = ~a;
      o_wr_data = ~d;
      @(negedge i_sys_clk);
   endtask
   // One read strobe, answer is watched by the bench
   task automatic rd(input logic [7:0] a);
      o_addr = a;
      o_rd_en = 1'b1;
      @(negedge i_sys_clk);
      o_rd_en = 1'b0;
      o_addr = ~a;
      @(negedge i_sys_clk);
   endtask
endmodule

// [sim/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
   logic i_sys_clk = 1'b0; // 200 MHz clock
   logic i_reset_n = 1'b0; // Reset, active low
   logic i_warm_reset_state = 1'b0; // Warm reset
   logic i_soft_reset = 1'b0; // Soft reset
   wire logic wr_en, rd_en; // Host strobes
   wire logic [7:0] addr; // Host address
   wire logic [15:0] wr_data; // Host data
   logic [19:0] o_rd_data; // Read data
   logic o_rd_valid; // Read valid
   logic [15:0] o_request; // Register
   ldr_pkg::ldr_hl_req_type o_hl_request; // High-level view
   ldr_pkg::ldr_ctrl_type o_ctrl; // Control lines
   logic [19:0] exp_q[$]; // Expected read answers
   int n_errors = 0;
   int checked = 0;
   logic [15:0] r = 16'h0043; // Random state
   logic [15:0] d; // Write value
   always #2.5 i_sys_clk = ~i_sys_clk;
   ldr_host_model u_host (.i_sys_clk(i_sys_clk), .o_wr_en(wr_en), .o_rd_en(rd_en),
      .o_addr(addr), .o_wr_data(wr_data));
   ldr_loop_diag_low_level_config u_dut (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
      .i_warm_reset_state(i_warm_reset_state), .i_soft_reset(i_soft_reset),
      .i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr), .i_wr_data(wr_data),
      .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .o_request(o_request),
      .o_hl_request(o_hl_request), .o_ctrl(o_ctrl));
   // Next value of the random sequence
   function automatic logic [15:0] nx(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic cmp_rd(input logic [19:0] got, input logic [19:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: read %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_ctl(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: control %h expected %h", $time, got, exp);
      end
   endtask
   // Note the answer, then read the register
   task automatic rd_exp(input logic [15:0] v);
      exp_q.push_back({4'h0, v});
      u_host.rd(8'h38);
   endtask
   task automatic final_report();
      if (exp_q.size() != 0)
         n_errors++;
      $display("comparisons %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Each answer against the oldest note; an unexpected answer always mismatches
   always @(negedge i_sys_clk)
      if (o_rd_valid === 1'b1)
         cmp_rd(o_rd_data, exp_q.size() ? exp_q.pop_front() : ~o_rd_data);
   initial
   begin
      #20000;
      n_errors++;
      final_report();
   end
   initial
   begin
      repeat (20) @(negedge i_sys_clk);
      i_reset_n = 1'b1;
      repeat (2) @(negedge i_sys_clk);
      cmp_ctl(o_ctrl.pulldown_on, 8'hff);
      rd_exp(16'h0000);
      u_host.wr(8'h38, 16'h0911);
      repeat (2) @(negedge i_sys_clk);
      cmp_ctl(o_ctrl.source_on, 8'h02);
      cmp_ctl(o_ctrl.mon_high_side, 8'h02);
      cmp_ctl(o_ctrl.pulldown_on, 8'hfd);
      rd_exp(16'h0911);
      $display("test walk done");
      // Every source, sink and monitor code, random channels, last eight high-level only when the random top bit is set
      for (int i = 0; i < 40; i++)
      begin
         r = nx(r);
         d = {i[5] & r[15], r[14:13], i[4:0], r[7:0]};
         if (d[9:8] == 2'h3)
            d[12:10] = 3'h0;
         u_host.wr(8'h38, d);
         u_host.wr(8'h39, ~d);
         rd_exp(d);
         u_host.rd(8'h37);
      end
      $display("test codes done");
      i_soft_reset = 1'b1;
      u_host.wr(8'h38, 16'h7fff);
      i_soft_reset = 1'b0;
      rd_exp(16'h0000);
      u_host.wr(8'h38, 16'h1234);
      i_warm_reset_state = 1'b1;
      @(negedge i_sys_clk);
      i_warm_reset_state = 1'b0;
      rd_exp(16'h0000);
      $display("test resets done");
      repeat (4) @(negedge i_sys_clk);
      final_report();
   end
endmodule
